// ==== common/cca_pkg.sv ====
// Constants shared by the counter array capture/compare unit
package cca_pkg;

   // ==========================================================
   // Geometry
   localparam int          NUM_MOD   = 5;
   localparam int          ADDR_W    = 12;
   localparam int          DATA_W    = 32;
   localparam int          IDX_W     = 10;

   // ==========================================================
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_MODE [0:NUM_MOD-1] =
      '{10'h0DA, 10'h0DB, 10'h0DC, 10'h0DD, 10'h0DE};
   localparam logic [IDX_W-1:0] IDX_CAPL [0:NUM_MOD-1] =
      '{10'h0FB, 10'h0E9, 10'h0EB, 10'h0ED, 10'h0FD};
   localparam logic [IDX_W-1:0] IDX_CAPH [0:NUM_MOD-1] =
      '{10'h0FC, 10'h0EA, 10'h0EC, 10'h0EE, 10'h0FE};
   localparam logic [IDX_W-1:0] IDX_CNT_LOW    = 10'h0F9;
   localparam logic [IDX_W-1:0] IDX_CNT_HIGH   = 10'h0FA;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h0C0;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR  = 10'h0C1;
   localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 10'h0C2;
   localparam logic [IDX_W-1:0] IDX_CTRL       = 10'h0C3;

   // ==========================================================
   // Mode and control register fields
   localparam int BIT_WIDE = 7;
   localparam int BIT_ECOM = 6;
   localparam int BIT_CAPP = 5;
   localparam int BIT_CAPN = 4;
   localparam int BIT_MAT  = 3;
   localparam int BIT_TOG  = 2;
   localparam int BIT_PWM  = 1;
   localparam int BIT_ECCF = 0;
   localparam int BIT_RUN  = 0;

   // ==========================================================
   // Reset values and responses
   localparam logic [7:0]         MODE_RST    = 8'h00;
   localparam logic [7:0]         CAPH_RST    = 8'h00;
   localparam logic [7:0]         CAPL_RST    = 8'h00;
   localparam logic [15:0]        CNT_RST     = 16'h0000;
   localparam logic [NUM_MOD-1:0] IRQ_EN_RST  = 5'h1F;
   localparam logic [1:0]         RESP_OKAY   = 2'h0;
   localparam logic [1:0]         RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/cca_module.sv ====
// One capture/compare module: capture, match, toggle and pulse-width output
`timescale 1ns/1ps
module cca_module
   import cca_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // Configuration and timebase
   input  wire logic [7:0]  mode,
   input  wire logic [15:0] cnt,
   input  wire logic        cnt_moved,
   input  wire logic        cnt_wrap,
   // Software access
   input  wire logic        wr_low,
   input  wire logic        wr_high,
   input  wire logic [7:0]  wr_byte,
   // Pin and results
   input  wire logic        pin_in,
   output logic [15:0]      cap_value,
   output logic             flag_set,
   output logic             pin_out,
   output logic             pin_oe
);

   // ==========================================================
   // Pin synchroniser and edge detection
   logic pin_meta;
   logic pin_sync;
   logic pin_prev;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // ==========================================================
   // Event decode
   logic rise;
   logic fall;
   logic capture_evt;
   logic full_eq;
   logic low_eq;
   logic pwm8;
   logic pwm16;
   logic freq;
   logic match_evt;

   assign rise        = pin_sync & ~pin_prev;
   assign fall        = ~pin_sync & pin_prev;
   assign capture_evt = (rise & mode[BIT_CAPP]) | (fall & mode[BIT_CAPN]);
   // Only a stepping counter matches, so a stopped one cannot retoggle
   assign full_eq     = mode[BIT_ECOM] & cnt_moved & (cnt == cap_value);
   assign low_eq      = mode[BIT_ECOM] & cnt_moved & (cnt[7:0] == cap_value[7:0]);
   assign pwm8        = mode[BIT_PWM] & ~mode[BIT_TOG] & ~mode[BIT_WIDE];
   assign pwm16       = mode[BIT_PWM] & ~mode[BIT_TOG] & mode[BIT_WIDE];
   assign freq        = mode[BIT_PWM] & mode[BIT_TOG];
   assign match_evt   = (freq | pwm8) ? low_eq : full_eq;
   assign flag_set    = capture_evt | (match_evt & mode[BIT_MAT]);

   // ==========================================================
   // Capture/compare value
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cap_value <= {CAPH_RST, CAPL_RST};
      end else if (capture_evt) begin
         cap_value <= cnt;
      end else begin
         if (freq && low_eq) begin
            cap_value[7:0] <= cap_value[7:0] + cap_value[15:8];
         end else if (pwm8 && cnt_wrap) begin
            cap_value[7:0] <= cap_value[15:8];
         end else if (wr_low) begin
            cap_value[7:0] <= wr_byte;
         end
         if (wr_high) begin
            cap_value[15:8] <= wr_byte;
         end
      end
   end

   // ==========================================================
   // Pin drive
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         pin_oe <= mode[BIT_ECOM] & (mode[BIT_TOG] | mode[BIT_PWM]);
         if (mode[BIT_ECOM] && pwm16) begin
            pin_out <= (cnt >= cap_value);
         end else if (mode[BIT_ECOM] && pwm8) begin
            pin_out <= (cnt[7:0] >= cap_value[7:0]);
         end else if (mode[BIT_TOG] && match_evt) begin
            pin_out <= ~pin_out;
         end
      end
   end

   // ==========================================================
   // Checks
   AST_CAPTURE_RISE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (rise && mode[BIT_CAPP]) |=> (cap_value == $past(cnt)))
      else $error("rising capture missed");
   AST_CAPTURE_FALL: assert property (@(posedge ref_clk) disable iff (!nrst)
      (fall && mode[BIT_CAPN]) |=> (cap_value == $past(cnt)))
      else $error("falling capture missed");
   AST_NO_CMP_FLAG: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!mode[BIT_ECOM] && !rise && !fall) |-> !flag_set)
      else $error("flag set without comparator");
   AST_MATCH_FLAG: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mode[BIT_ECOM] && mode[BIT_MAT] && !mode[BIT_PWM] && cnt_moved
       && cnt == cap_value) |-> flag_set)
      else $error("match did not set flag");
   AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mode[BIT_TOG] && !mode[BIT_PWM] && full_eq) |=> (pin_out != $past(pin_out)))
      else $error("pin did not toggle");
   AST_PWM16: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mode[BIT_ECOM] && pwm16) |=> (pin_out == ($past(cnt) >= $past(cap_value))))
      else $error("16-bit pwm level wrong");
   AST_PWM8: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mode[BIT_ECOM] && pwm8)
      |=> (pin_out == ($past(cnt[7:0]) >= $past(cap_value[7:0]))))
      else $error("8-bit pwm level wrong");
   AST_CAPH_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (wr_high && !capture_evt) |=> (cap_value[15:8] == $past(wr_byte)))
      else $error("high byte write lost");

endmodule

// ==== rtl/cca_top.sv ====
// Counter array capture/compare unit with AXI4-Lite register access
//
// Summary of operation
// - PWM width bit picks 8 or 16 bits
// - Rising pin edge captures when enabled
// - Falling pin edge captures when enabled
// - Match enable sets flag on equal
// - Toggle pin on match; with PWM, frequency
// - PWM enable drives modulated pin waveform
// - Interrupt when flag, its ECCF mode bit and its enable set
// - Counter low byte readable and writable
// - Capture low register holds value low byte
// - Capture high register holds high, resets zero
`timescale 1ns/1ps
module cca_top
   import cca_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Module pins
   input  wire logic [NUM_MOD-1:0] module_io_pin_in,
   output logic [NUM_MOD-1:0]      module_io_pin_out,
   output logic [NUM_MOD-1:0]      module_io_pin_oe,
   // Interrupt
   output logic                    irq
);

   // ==========================================================
   // Write channel capture
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [7:0]        w_byte_q;
   logic              w_lane0_q;
   logic              do_write;
   logic              wr_hit;
   logic [IDX_W-1:0]  wr_idx;
   logic              wr_mapped;

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign do_write      = aw_held & w_held & ~s_axi_bvalid;
   assign wr_idx        = aw_addr_q[ADDR_W-1:2];
   // Only byte lane 0 carries register data; other lanes are ignored
   assign wr_hit        = do_write & w_lane0_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         aw_held   <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held   <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held   <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         w_held    <= 1'b0;
         w_byte_q  <= '0;
         w_lane0_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held    <= 1'b1;
         w_byte_q  <= s_axi_wdata[7:0];
         w_lane0_q <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held    <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Counter/timer
   logic [15:0] cnt;
   logic        run;
   logic        cnt_moved;
   logic        cnt_wrap;
   logic        cnt_wr;

   assign cnt_wr   = wr_hit & ((wr_idx == IDX_CNT_LOW) | (wr_idx == IDX_CNT_HIGH));
   assign cnt_wrap = cnt_moved & (cnt[7:0] == CNT_RST[7:0]);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= CNT_RST;
      end else if (wr_hit && wr_idx == IDX_CNT_LOW) begin
         cnt[7:0] <= w_byte_q;
      end else if (wr_hit && wr_idx == IDX_CNT_HIGH) begin
         cnt[15:8] <= w_byte_q;
      end else if (run) begin
         cnt <= cnt + 16'h0001;
      end
   end

   // Marks a cycle whose count is fresh, so matches fire once per value
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_moved <= 1'b0;
      end else begin
         cnt_moved <= run & ~cnt_wr;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         run <= 1'b0;
      end else if (wr_hit && wr_idx == IDX_CTRL) begin
         run <= w_byte_q[BIT_RUN];
      end
   end

   // ==========================================================
   // Modules
   logic [7:0]         mode [0:NUM_MOD-1];
   logic [15:0]        cap  [0:NUM_MOD-1];
   logic [NUM_MOD-1:0] flag_set;
   logic [NUM_MOD-1:0] eccf;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               mode[gi] <= MODE_RST;
            end else if (wr_hit && wr_idx == IDX_MODE[gi]) begin
               mode[gi] <= w_byte_q;
            end
         end

         assign eccf[gi] = mode[gi][BIT_ECCF];

         cca_module u_mod (
            .ref_clk   (ref_clk),
            .nrst      (nrst),
            .mode      (mode[gi]),
            .cnt       (cnt),
            .cnt_moved (cnt_moved),
            .cnt_wrap  (cnt_wrap),
            .wr_low    (wr_hit && wr_idx == IDX_CAPL[gi]),
            .wr_high   (wr_hit && wr_idx == IDX_CAPH[gi]),
            .wr_byte   (w_byte_q),
            .pin_in    (module_io_pin_in[gi]),
            .cap_value (cap[gi]),
            .flag_set  (flag_set[gi]),
            .pin_out   (module_io_pin_out[gi]),
            .pin_oe    (module_io_pin_oe[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Capture/compare flags and interrupt
   logic [NUM_MOD-1:0] capture_compare_flag;
   logic [NUM_MOD-1:0] irq_enable;
   logic [NUM_MOD-1:0] flag_clr;

   assign flag_clr = (wr_hit && wr_idx == IDX_IRQ_CLEAR) ? w_byte_q[NUM_MOD-1:0] : '0;

   // A set arriving with its clear wins, so no event is lost
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         capture_compare_flag <= '0;
      end else begin
         capture_compare_flag <= (capture_compare_flag & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         irq_enable <= IRQ_EN_RST;
      end else if (wr_hit && wr_idx == IDX_IRQ_ENABLE) begin
         irq_enable <= w_byte_q[NUM_MOD-1:0];
      end
   end

   assign irq = |(capture_compare_flag & eccf & irq_enable);

   // ==========================================================
   // Address decode and read path
   logic [IDX_W-1:0] rd_idx;
   logic [7:0]       rd_byte;
   logic             rd_mapped;

   assign rd_idx        = s_axi_araddr[ADDR_W-1:2];
   assign s_axi_arready = ~s_axi_rvalid;

   always_comb begin
      rd_byte   = 8'h00;
      rd_mapped = 1'b1;
      if (rd_idx == IDX_CNT_LOW) begin
         rd_byte = cnt[7:0];
      end else if (rd_idx == IDX_CNT_HIGH) begin
         rd_byte = cnt[15:8];
      end else if (rd_idx == IDX_IRQ_STATUS) begin
         rd_byte = {{(8-NUM_MOD){1'b0}}, capture_compare_flag};
      end else if (rd_idx == IDX_IRQ_CLEAR) begin
         rd_byte = 8'h00;
      end else if (rd_idx == IDX_IRQ_ENABLE) begin
         rd_byte = {{(8-NUM_MOD){1'b0}}, irq_enable};
      end else if (rd_idx == IDX_CTRL) begin
         rd_byte = {7'h00, run};
      end else begin
         rd_mapped = 1'b0;
      end
      for (int i = 0; i < NUM_MOD; i++) begin
         if (rd_idx == IDX_MODE[i]) begin
            rd_byte   = mode[i];
            rd_mapped = 1'b1;
         end
         if (rd_idx == IDX_CAPL[i]) begin
            rd_byte   = cap[i][7:0];
            rd_mapped = 1'b1;
         end
         if (rd_idx == IDX_CAPH[i]) begin
            rd_byte   = cap[i][15:8];
            rd_mapped = 1'b1;
         end
      end
   end

   always_comb begin
      wr_mapped = (wr_idx == IDX_CNT_LOW) | (wr_idx == IDX_CNT_HIGH)
                | (wr_idx == IDX_IRQ_STATUS) | (wr_idx == IDX_IRQ_CLEAR)
                | (wr_idx == IDX_IRQ_ENABLE) | (wr_idx == IDX_CTRL);
      for (int i = 0; i < NUM_MOD; i++) begin
         wr_mapped = wr_mapped | (wr_idx == IDX_MODE[i])
                   | (wr_idx == IDX_CAPL[i]) | (wr_idx == IDX_CAPH[i]);
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, rd_byte};
         s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   sequence seq_rd_cnt_low;
      s_axi_arvalid && s_axi_arready && rd_idx == IDX_CNT_LOW;
   endsequence

   sequence seq_rd_capl0;
      s_axi_arvalid && s_axi_arready && rd_idx == IDX_CAPL[0];
   endsequence

   sequence seq_wr_capture;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_wstrb[0] && s_axi_awaddr[ADDR_W-1:2] == IDX_CAPL[0];
   endsequence

   AST_READ_CNT_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
      seq_rd_cnt_low |=> (s_axi_rvalid && s_axi_rdata[7:0] == $past(cnt[7:0])))
      else $error("counter low byte read wrong");
   AST_READ_CAPL0: assert property (@(posedge ref_clk) disable iff (!nrst)
      seq_rd_capl0 |=> (s_axi_rvalid && s_axi_rdata[7:0] == $past(cap[0][7:0])))
      else $error("capture low byte read wrong");
   AST_WRITE_CAPL0: assert property (@(posedge ref_clk) disable iff (!nrst)
      (seq_wr_capture ##1 (!flag_set[0] && !mode[0][BIT_PWM]))
      |=> (cap[0][7:0] == $past(w_byte_q) && s_axi_bvalid))
      else $error("capture low byte write lost");
   AST_IRQ: assert property (@(posedge ref_clk) disable iff (!nrst)
      (irq == |(capture_compare_flag & eccf & irq_enable)) and (!(|eccf) |-> !irq))
      else $error("interrupt level wrong");
   AST_FLAG_SET_WINS: assert property (@(posedge ref_clk) disable iff (!nrst)
      (|(flag_set & flag_clr))
      |=> (|(capture_compare_flag & $past(flag_set) & $past(flag_clr))))
      else $error("flag clear beat a set");
   AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
      (flag_clr[0] && !flag_set[0]) |=> !capture_compare_flag[0])
      else $error("flag clear ignored");
   AST_BRESP_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
      (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
      else $error("write response dropped");
   AST_RDATA_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
      (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
      else $error("read data dropped");

endmodule

// ==== tb/cca_pin_model.sv ====
// Far-side model of the module pins and their outside drivers
`timescale 1ns/1ps
module cca_pin_model
   import cca_pkg::*;
(
   // Bench control
   input  wire logic [NUM_MOD-1:0] ext_level,
   // Device side
   input  wire logic [NUM_MOD-1:0] pin_out,
   input  wire logic [NUM_MOD-1:0] pin_oe,
   output logic [NUM_MOD-1:0]      pin_in
);
   // ==========================================================
   // Line level
   // Device wins while it drives, so no contention is modelled
   always_comb begin
      for (int i = 0; i < NUM_MOD; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
      end
   end
endmodule

// ==== tb/cca_top_tb_top.sv ====
// Self-checking testbench of the capture/compare unit
`timescale 1ns/1ps
module cca_top_tb_top
   import cca_pkg::*;
;
   // ==========================================================
   // Signals
   logic                ref_clk, nrst;
   logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
   logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [DATA_W-1:0]   s_axi_wdata, s_axi_rdata;
   logic [3:0]          s_axi_wstrb;
   logic [1:0]          s_axi_bresp, s_axi_rresp, last_bresp;
   logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                s_axi_rvalid, s_axi_rready, irq;
   logic [NUM_MOD-1:0]  pin_in, pin_out, pin_oe, ext_level;
   int                  n_mismatch, comparisons, cyc;

   cca_top cca_top_inst (.ref_clk(ref_clk), .nrst(nrst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
      .module_io_pin_oe(pin_oe), .irq(irq));

   cca_pin_model cca_pin_model_inst (.ext_level(ext_level), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_in(pin_in));

   // ==========================================================
   // Clock and watchdog
   always #2.5 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // ==========================================================
   // Bus and compare tasks
   // Ready is looked at on the falling edge so the taking edge never races
   task automatic axi_wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      logic a_ok, w_ok, a_now, w_now;
      a_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge ref_clk);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_wstrb   <= 4'hF;
      s_axi_wvalid  <= 1'b1;
      while (!(a_ok && w_ok)) begin
         @(negedge ref_clk);
         a_now = s_axi_awvalid && s_axi_awready;
         w_now = s_axi_wvalid && s_axi_wready;
         @(posedge ref_clk);
         if (a_now) begin
            s_axi_awvalid <= 1'b0;
            a_ok = 1'b1;
         end
         if (w_now) begin
            s_axi_wvalid <= 1'b0;
            w_ok = 1'b1;
         end
      end
      s_axi_bready <= 1'b1;
      do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
      last_bresp = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [IDX_W-1:0] idx, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      s_axi_rready  <= 1'b1;
      do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask

   task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] exp, input string nm);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(idx, d, r);
      chk(nm, {24'h000000, exp}, d);
      chk({nm, "_resp"}, {30'h0, RESP_OKAY}, {30'h0, r});
   endtask

   task automatic pin_step(input int i, input logic lvl);
      @(posedge ref_clk);
      ext_level[i] <= lvl;
      repeat (8) @(posedge ref_clk);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset_vals();
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < NUM_MOD; i++) begin
         rd_chk(IDX_MODE[i], MODE_RST, "mode");
         rd_chk(IDX_CAPH[i], 8'h00, "cap_high_rst");
      end
      axi_rd(10'h3FF, d, r);
      chk("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi_wr(10'h3FF, 8'h5A);
      chk("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, last_bresp});
   endtask

   task automatic t_regs();
      for (int i = 0; i < NUM_MOD; i++) begin
         axi_wr(IDX_CAPL[i], 8'hA0 + 8'(i));
         axi_wr(IDX_CAPH[i], 8'h50 + 8'(i));
      end
      for (int i = 0; i < NUM_MOD; i++) begin
         rd_chk(IDX_CAPL[i], 8'hA0 + 8'(i), "cap_low");
         rd_chk(IDX_CAPH[i], 8'h50 + 8'(i), "cap_high");
      end
      axi_wr(IDX_CNT_LOW, 8'h77);
      rd_chk(IDX_CNT_LOW, 8'h77, "cnt_low");
   endtask

   task automatic t_capture();
      axi_wr(IDX_CNT_LOW, 8'h34);
      axi_wr(IDX_CNT_HIGH, 8'h12);
      axi_wr(IDX_CAPL[0], 8'h00);
      axi_wr(IDX_CAPH[0], 8'h00);
      axi_wr(IDX_MODE[0], 8'h10);
      pin_step(0, 1'b1);
      rd_chk(IDX_CAPL[0], 8'h00, "cap_rise_off");
      pin_step(0, 1'b0);
      rd_chk(IDX_CAPL[0], 8'h34, "cap_low_fall");
      rd_chk(IDX_CAPH[0], 8'h12, "cap_high_fall");
      rd_chk(IDX_IRQ_STATUS, 8'h01, "status_cap");
      axi_wr(IDX_CNT_LOW, 8'h56);
      axi_wr(IDX_MODE[0], 8'h20);
      pin_step(0, 1'b1);
      rd_chk(IDX_CAPL[0], 8'h56, "cap_low_rise");
      axi_wr(IDX_CNT_LOW, 8'h78);
      pin_step(0, 1'b0);
      rd_chk(IDX_CAPL[0], 8'h56, "cap_fall_off");
   endtask

   task automatic t_irq();
      axi_wr(IDX_MODE[0], 8'h21);
      @(negedge ref_clk);
      chk("irq_on", 1, irq);
      axi_wr(IDX_IRQ_ENABLE, 8'h1E);
      @(negedge ref_clk);
      chk("irq_masked", 0, irq);
      axi_wr(IDX_IRQ_ENABLE, 8'h1F);
      axi_wr(IDX_MODE[0], 8'h20);
      @(negedge ref_clk);
      chk("irq_mode_off", 0, irq);
      axi_wr(IDX_MODE[0], 8'h21);
      axi_wr(IDX_IRQ_CLEAR, 8'h1F);
      @(negedge ref_clk);
      chk("irq_cleared", 0, irq);
      rd_chk(IDX_IRQ_STATUS, 8'h00, "status_clr");
      axi_wr(IDX_MODE[0], 8'h00);
   endtask

   task automatic t_match();
      axi_wr(IDX_CTRL, 8'h00);
      axi_wr(IDX_CNT_LOW, 8'h00);
      axi_wr(IDX_CNT_HIGH, 8'h00);
      for (int i = 1; i < 4; i++) begin
         axi_wr(IDX_CAPL[i], 8'h10);
         axi_wr(IDX_CAPH[i], 8'h00);
      end
      axi_wr(IDX_MODE[1], 8'h48);
      axi_wr(IDX_MODE[2], 8'h08);
      axi_wr(IDX_MODE[3], 8'h44);
      axi_wr(IDX_IRQ_CLEAR, 8'h1F);
      axi_wr(IDX_CTRL, 8'h01);
      repeat (40) @(posedge ref_clk);
      axi_wr(IDX_CTRL, 8'h00);
      rd_chk(IDX_IRQ_STATUS, 8'h02, "status_match");
      @(negedge ref_clk);
      chk("toggle_pin", 1, pin_out[3]);
      chk("toggle_oe", 1, pin_oe[3]);
   endtask

   // Counter 0x021x against 0x01F0: only the 16-bit compare sees it as above
   task automatic t_pwm();
      axi_wr(IDX_CAPL[4], 8'hF0);
      axi_wr(IDX_CAPH[4], 8'h01);
      for (int w = 1; w >= 0; w--) begin
         axi_wr(IDX_CTRL, 8'h00);
         axi_wr(IDX_CNT_LOW, 8'h10);
         axi_wr(IDX_CNT_HIGH, 8'h02);
         axi_wr(IDX_MODE[4], (w == 1) ? 8'hC2 : 8'h42);
         axi_wr(IDX_CTRL, 8'h01);
         repeat (4) @(posedge ref_clk);
         @(negedge ref_clk);
         chk("pwm_pin", 32'(w), pin_out[4]);
         chk("pwm_oe", 1, pin_oe[4]);
      end
   endtask

   // Low byte match at 0x20 adds the high byte once; next match lies beyond the run
   task automatic t_freq();
      axi_wr(IDX_CTRL, 8'h00);
      axi_wr(IDX_CNT_LOW, 8'h00);
      axi_wr(IDX_CNT_HIGH, 8'h00);
      axi_wr(IDX_CAPL[2], 8'h20);
      axi_wr(IDX_CAPH[2], 8'h80);
      axi_wr(IDX_MODE[2], 8'h46);
      axi_wr(IDX_CTRL, 8'h01);
      repeat (40) @(posedge ref_clk);
      axi_wr(IDX_CTRL, 8'h00);
      rd_chk(IDX_CAPL[2], 8'hA0, "freq_next");
      @(negedge ref_clk);
      chk("freq_pin", 1, pin_out[2]);
      chk("freq_oe", 1, pin_oe[2]);
   endtask

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      ext_level = '0;
      n_mismatch = 0;
      comparisons = 0;
      cyc = 0;
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset_vals();
      t_regs();
      t_capture();
      t_irq();
      t_match();
      t_pwm();
      t_freq();
      complete_run();
   end
endmodule
